/* cci_pkg.sv */
package cci_pkg;

    // =========================================================
    // Widths
    // =========================================================
    localparam int DATA_W     = 8;
    localparam int PC_W       = 11;
    localparam int FADDR_W    = 5;
    localparam int PAGE_W     = 2;
    localparam int STACK_DEPTH = 2;

    // =========================================================
    // Program counter field layout
    // =========================================================
    localparam int PC_LIT_HI  = 7;
    localparam int PC_BIT8    = 8;
    localparam int PC_PAGE_LO = 9;
    localparam int PC_PAGE_HI = 10;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [PC_W-1:0]   PC_RESET   = 11'h000;
    localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
    localparam logic              ZERO_RESET = 1'b0;
    localparam logic              FLAG_N_RESET = 1'b1;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ONE   = 8'h01;
    localparam logic [PC_W-1:0]   PC_ONE     = 11'h001;

    // =========================================================
    // Timing
    // =========================================================
    localparam int CALL_CYCLES = 2;

    // =========================================================
    // Operation selector
    // =========================================================
    typedef enum logic [2:0] {
        CCI_OP_NONE                 = 3'h0,
        CCI_OP_ACCUMULATOR_CLEAR    = 3'h1,
        CCI_OP_CALL                 = 3'h2,
        CCI_OP_WATCHDOG_CLEAR       = 3'h3,
        CCI_OP_FILE_CLEAR           = 3'h4,
        CCI_OP_FILE_COMPLEMENT      = 3'h5,
        CCI_OP_FILE_DECREMENT       = 3'h6,
        CCI_OP_FILE_INCREMENT       = 3'h7
    } cci_op_t;

endpackage : cci_pkg

/* cci_return_stack.sv */
`timescale 1ns/1ns
module cci_return_stack #(
    parameter int DEPTH = cci_pkg::STACK_DEPTH,
    parameter int WIDTH = cci_pkg::PC_W
) (
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic             push_in,
    input  wire logic [WIDTH-1:0] push_data_in,
    output logic      [WIDTH-1:0] top_out
);

    // =========================================================
    // Checks
    // =========================================================
    if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
        $error("cci_return_stack: DEPTH and WIDTH must be at least 1");
    end

    // =========================================================
    // Storage
    // =========================================================
    // Overflow silently drops the oldest entry, as a shift stack does
    logic [WIDTH-1:0] entry_q [DEPTH];

    assign top_out = entry_q[0];

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                entry_q[i] <= '0;
            end
        end else if (push_in) begin
            entry_q[0] <= push_data_in;
            for (int i = 1; i < DEPTH; i++) begin
                entry_q[i] <= entry_q[i-1];
            end
        end
    end

endmodule : cci_return_stack

/* cci_exec.sv */
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module cci_exec #(
    parameter int STACK_DEPTH = cci_pkg::STACK_DEPTH
) (
    input  wire logic                          clk_in,
    input  wire logic                          reset_n_in,
    input  wire logic                          op_valid_in,
    input  wire logic [2:0]                    op_code_in,
    input  wire logic [cci_pkg::FADDR_W-1:0]   file_addr_in,
    input  wire logic                          dest_in,
    input  wire logic [cci_pkg::DATA_W-1:0]    literal_in,
    input  wire logic [cci_pkg::DATA_W-1:0]    file_rdata_in,
    input  wire logic [cci_pkg::PAGE_W-1:0]    status_page_in,
    input  wire logic                          prescaler_to_wdt_in,
    output logic      [cci_pkg::PC_W-1:0]      program_counter_out,
    output logic      [cci_pkg::DATA_W-1:0]    accumulator_out,
    output logic                               zero_flag_out,
    output logic                               timeout_flag_n_out,
    output logic                               powerdown_flag_n_out,
    output logic                               file_we_out,
    output logic      [cci_pkg::FADDR_W-1:0]   file_waddr_out,
    output logic      [cci_pkg::DATA_W-1:0]    file_wdata_out,
    output logic                               watchdog_counter_clear_out,
    output logic                               prescaler_clear_out,
    output logic                               busy_out,
    output logic      [cci_pkg::PC_W-1:0]      stack_top_out
);

    // =========================================================
    // Checks
    // =========================================================
    if (STACK_DEPTH < 1) begin : g_bad_depth
        $error("cci_exec: STACK_DEPTH must be at least 1");
    end
    if (cci_pkg::CALL_CYCLES != 2) begin : g_bad_call
        $error("cci_exec: only a two-cycle call is supported");
    end

    // =========================================================
    // State
    // =========================================================
    typedef enum logic [0:0] {
        CCI_ST_RUN,
        CCI_ST_FLUSH
    } cci_state_t;

    cci_state_t                     state_q;
    cci_state_t                     state_d;
    logic [cci_pkg::PC_W-1:0]       pc_q;
    logic [cci_pkg::PC_W-1:0]       pc_d;
    logic [cci_pkg::DATA_W-1:0]     acc_q;
    logic [cci_pkg::DATA_W-1:0]     acc_d;
    logic                           zero_q;
    logic                           zero_d;
    logic                           to_n_q;
    logic                           to_n_d;
    logic                           pd_n_q;
    logic                           pd_n_d;
    logic                           fwe_q;
    logic [cci_pkg::FADDR_W-1:0]    fwaddr_q;
    logic [cci_pkg::DATA_W-1:0]     fwdata_q;
    logic                           wdt_clr_q;
    logic                           pre_clr_q;
    logic                           busy_q;

    // =========================================================
    // Decode
    // =========================================================
    // A fetched instruction seen during the flush cycle is dropped, so the
    // call's delay slot never executes
    wire take_w      = op_valid_in && (state_q == CCI_ST_RUN);
    wire is_accclr_w = take_w && (op_code_in == cci_pkg::CCI_OP_ACCUMULATOR_CLEAR);
    wire is_call_w   = take_w && (op_code_in == cci_pkg::CCI_OP_CALL);
    wire is_wdtclr_w = take_w && (op_code_in == cci_pkg::CCI_OP_WATCHDOG_CLEAR);
    wire is_fclr_w   = take_w && (op_code_in == cci_pkg::CCI_OP_FILE_CLEAR);
    wire is_comp_w   = take_w && (op_code_in == cci_pkg::CCI_OP_FILE_COMPLEMENT);
    wire is_dec_w    = take_w && (op_code_in == cci_pkg::CCI_OP_FILE_DECREMENT);
    wire is_inc_w    = take_w && (op_code_in == cci_pkg::CCI_OP_FILE_INCREMENT);
    wire is_arith_w  = is_comp_w || is_dec_w || is_inc_w;

    // =========================================================
    // Datapath
    // =========================================================
    wire [cci_pkg::DATA_W-1:0] comp_res_w = ~file_rdata_in;
    wire [cci_pkg::DATA_W-1:0] dec_res_w  = cci_pkg::DATA_W'(file_rdata_in - cci_pkg::DATA_ONE);
    wire [cci_pkg::DATA_W-1:0] inc_res_w  = cci_pkg::DATA_W'(file_rdata_in + cci_pkg::DATA_ONE);

    wire [cci_pkg::DATA_W-1:0] arith_res_w =
        is_comp_w ? comp_res_w :
        is_dec_w  ? dec_res_w  :
                    inc_res_w;

    wire arith_zero_w = (arith_res_w == cci_pkg::DATA_ZERO);
    wire to_acc_w     = is_arith_w && !dest_in;
    wire to_file_w    = is_arith_w &&  dest_in;

    wire [cci_pkg::PC_W-1:0] pc_next_w = cci_pkg::PC_W'(pc_q + cci_pkg::PC_ONE);

    // Target keeps page bits from status, bit 8 forced low
    wire [cci_pkg::PC_W-1:0] call_target_w = {
        status_page_in,
        1'b0,
        literal_in
    };

    // =========================================================
    // Next-state logic
    // =========================================================
    always_comb begin
        state_d = state_q;
        pc_d    = pc_q;
        acc_d   = acc_q;
        zero_d  = zero_q;
        to_n_d  = to_n_q;
        pd_n_d  = pd_n_q;
        case (state_q)
            CCI_ST_RUN: begin
                if (take_w) begin
                    pc_d = pc_next_w;
                end
                if (is_call_w) begin
                    pc_d    = call_target_w;
                    state_d = CCI_ST_FLUSH;
                end
                if (is_accclr_w) begin
                    acc_d  = cci_pkg::DATA_ZERO;
                    zero_d = 1'b1;
                end
                if (is_fclr_w) begin
                    zero_d = 1'b1;
                end
                if (is_wdtclr_w) begin
                    to_n_d = 1'b1;
                    pd_n_d = 1'b1;
                end
                if (is_arith_w) begin
                    zero_d = arith_zero_w;
                end
                if (to_acc_w) begin
                    acc_d = arith_res_w;
                end
            end
            CCI_ST_FLUSH: begin
                // Second call cycle: the slot instruction is a no-op, so the
                // counter stays on the target and a nested call returns right
                pc_d    = pc_q;
                state_d = CCI_ST_RUN;
            end
            default: begin
                state_d = CCI_ST_RUN;
            end
        endcase
    end

    // =========================================================
    // Registers
    // =========================================================
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= CCI_ST_RUN;
            pc_q    <= cci_pkg::PC_RESET;
            acc_q   <= cci_pkg::ACC_RESET;
            zero_q  <= cci_pkg::ZERO_RESET;
            to_n_q  <= cci_pkg::FLAG_N_RESET;
            pd_n_q  <= cci_pkg::FLAG_N_RESET;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
            acc_q   <= acc_d;
            zero_q  <= zero_d;
            to_n_q  <= to_n_d;
            pd_n_q  <= pd_n_d;
        end
    end

    // File write port and one-cycle side effects
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fwe_q     <= 1'b0;
            fwaddr_q  <= '0;
            fwdata_q  <= cci_pkg::DATA_ZERO;
            wdt_clr_q <= 1'b0;
            pre_clr_q <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            fwe_q     <= is_fclr_w || to_file_w;
            fwaddr_q  <= file_addr_in;
            fwdata_q  <= is_fclr_w ? cci_pkg::DATA_ZERO : arith_res_w;
            wdt_clr_q <= is_wdtclr_w;
            pre_clr_q <= is_wdtclr_w && prescaler_to_wdt_in;
            busy_q    <= (state_d == CCI_ST_FLUSH);
        end
    end

    // =========================================================
    // Return stack
    // =========================================================
    cci_return_stack #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (cci_pkg::PC_W)
    ) u_stack (
        .clk_in       (clk_in),
        .reset_n_in   (reset_n_in),
        .push_in      (is_call_w),
        .push_data_in (pc_next_w),
        .top_out      (stack_top_out)
    );

    // =========================================================
    // Outputs
    // =========================================================
    assign program_counter_out        = pc_q;
    assign accumulator_out            = acc_q;
    assign zero_flag_out              = zero_q;
    assign timeout_flag_n_out         = to_n_q;
    assign powerdown_flag_n_out       = pd_n_q;
    assign file_we_out                = fwe_q;
    assign file_waddr_out             = fwaddr_q;
    assign file_wdata_out             = fwdata_q;
    assign watchdog_counter_clear_out = wdt_clr_q;
    assign prescaler_clear_out        = pre_clr_q;
    assign busy_out                   = busy_q;

endmodule : cci_exec

/* cci_exec_props.sv */
`timescale 1ns/1ns
module cci_exec_props (
    input wire logic                        clk_in,
    input wire logic                        reset_n_in,
    input wire logic                        op_valid_in,
    input wire logic [2:0]                  op_code_in,
    input wire logic [cci_pkg::FADDR_W-1:0] file_addr_in,
    input wire logic                        dest_in,
    input wire logic [cci_pkg::DATA_W-1:0]  literal_in,
    input wire logic [cci_pkg::DATA_W-1:0]  file_rdata_in,
    input wire logic [cci_pkg::PAGE_W-1:0]  status_page_in,
    input wire logic                        prescaler_to_wdt_in,
    input wire logic [cci_pkg::PC_W-1:0]    program_counter_out,
    input wire logic [cci_pkg::DATA_W-1:0]  accumulator_out,
    input wire logic                        zero_flag_out,
    input wire logic                        timeout_flag_n_out,
    input wire logic                        powerdown_flag_n_out,
    input wire logic                        file_we_out,
    input wire logic [cci_pkg::FADDR_W-1:0] file_waddr_out,
    input wire logic [cci_pkg::DATA_W-1:0]  file_wdata_out,
    input wire logic                        watchdog_counter_clear_out,
    input wire logic                        prescaler_clear_out,
    input wire logic                        busy_out,
    input wire logic [cci_pkg::PC_W-1:0]    stack_top_out
);
    // =========================================================
    // Sequences and properties
    // =========================================================
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // An op seen in the flush cycle is dropped, so it never counts as taken
    sequence s_take(logic [2:0] c);
        op_valid_in && !busy_out && op_code_in == c;
    endsequence
    sequence s_flush;
        busy_out ##1 (!busy_out && !file_we_out);
    endsequence
    property p_acc_clr;
        s_take(3'h1) |=> accumulator_out == 8'h00 && zero_flag_out;
    endproperty
    property p_call_tgt;
        s_take(3'h2) |=> program_counter_out == {$past(status_page_in), 1'b0, $past(literal_in)};
    endproperty
    property p_call_push;
        s_take(3'h2) |=> stack_top_out == $past(program_counter_out) + 11'h001;
    endproperty
    property p_call_len;
        s_take(3'h2) |=> s_flush ##0 program_counter_out == $past(program_counter_out);
    endproperty
    property p_wdt;
        s_take(3'h3) |=> watchdog_counter_clear_out && timeout_flag_n_out && powerdown_flag_n_out;
    endproperty
    property p_pre;
        s_take(3'h3) |=> prescaler_clear_out == $past(prescaler_to_wdt_in);
    endproperty
    property p_fclr;
        s_take(3'h4) |=> file_we_out && file_wdata_out == 8'h00 && zero_flag_out
            && file_waddr_out == $past(file_addr_in);
    endproperty
    property p_file_complement_op;
        s_take(3'h5) ##0 dest_in |=> file_we_out && file_wdata_out == ~$past(file_rdata_in);
    endproperty
    property p_dest0;
        op_valid_in && !busy_out && op_code_in >= 3'h5 && !dest_in |=> !file_we_out;
    endproperty
    property p_dec;
        s_take(3'h6) ##0 !dest_in |=> accumulator_out == $past(file_rdata_in) - 8'h01;
    endproperty
    property p_inc;
        s_take(3'h7) ##0 dest_in |=> file_wdata_out == $past(file_rdata_in) + 8'h01
            && zero_flag_out == ($past(file_rdata_in) == 8'hFF);
    endproperty
    property p_flags;
        !(op_valid_in && !busy_out && op_code_in == 3'h3)
            |=> $stable(timeout_flag_n_out) && $stable(powerdown_flag_n_out);
    endproperty
    property p_one;
        op_valid_in && !busy_out && op_code_in != 3'h0 && op_code_in != 3'h2
            |=> program_counter_out == $past(program_counter_out) + 11'h001;
    endproperty
    // =========================================================
    // Assertions
    // =========================================================
    a_acc_clr: assert property (p_acc_clr) else $error("acc clear result wrong");
    a_call_push: assert property (p_call_push) else $error("call push wrong");
    a_call_tgt: assert property (p_call_tgt) else $error("call target wrong");
    a_call_len: assert property (p_call_len) else $error("call flush wrong");
    a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
    a_pre: assert property (p_pre) else $error("prescaler clear wrong");
    a_fclr: assert property (p_fclr) else $error("file clear wrong");
    a_file_complement_op: assert property (p_file_complement_op) else $error("complement wrong");
    a_dest0: assert property (p_dest0) else $error("file written for dest 0");
    a_dec: assert property (p_dec) else $error("decrement wrong");
    a_inc: assert property (p_inc) else $error("increment wrong");
    a_flags: assert property (p_flags) else $error("active-low flag cleared");
    a_one: assert property (p_one) else $error("single-cycle op pc wrong");
endmodule : cci_exec_props

bind cci_exec cci_exec_props cci_exec_props_i (.*);

/* test_clear_call_incdec_exec.sv */
`timescale 1ns/1ns
module test_clear_call_incdec_exec;
    logic        clk_in, reset_n_in, op_valid_in, dest_in, prescaler_to_wdt_in;
    logic [2:0]  op_code_in;
    logic [4:0]  file_addr_in, file_waddr_out;
    logic [7:0]  literal_in, file_rdata_in, accumulator_out, file_wdata_out;
    logic [1:0]  status_page_in;
    logic [10:0] program_counter_out, stack_top_out, exp_pc;
    logic        zero_flag_out, timeout_flag_n_out, powerdown_flag_n_out, file_we_out;
    logic        watchdog_counter_clear_out, prescaler_clear_out, busy_out;
    int          fail_count, checks_done;

    cci_exec cci_exec_i (.*);

    // =========================================================
    // Compare and drive tasks
    // =========================================================
    task automatic chk_pc(input string n, input logic [10:0] e, input logic [10:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk_pc
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk_byte
    task automatic chk_bit(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk_bit
    // One op, presented for one cycle; results checked once its edge has landed
    task automatic issue(input logic [2:0] c, input logic d, input logic [7:0] r);
        @(posedge clk_in);
        op_valid_in <= 1'b1;
        op_code_in <= c;
        dest_in <= d;
        file_rdata_in <= r;
        file_addr_in <= {2'h3, c};
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        #1;
        exp_pc = exp_pc + 11'h001;
    endtask : issue
    task automatic print_verdict;
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic t_reset;
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        chk_pc("pc", 11'h000, program_counter_out);
        chk_pc("stack", 11'h000, stack_top_out);
        chk_byte("acc", 8'h00, accumulator_out);
        chk_bit("busy", 1'b0, busy_out);
        chk_bit("to_n", 1'b1, timeout_flag_n_out);
        chk_bit("pd_n", 1'b1, powerdown_flag_n_out);
        reset_n_in <= 1'b1;
        exp_pc = 11'h000;
    endtask : t_reset
    task automatic t_acc;
        issue(3'h7, 1'b0, 8'h41);
        chk_byte("acc", 8'h42, accumulator_out);
        issue(3'h1, 1'b0, 8'h41);
        chk_byte("acc", 8'h00, accumulator_out);
        chk_bit("zero", 1'b1, zero_flag_out);
        chk_pc("pc", exp_pc, program_counter_out);
    endtask : t_acc
    // Wraparound at both ends, both destinations, every file op
    task automatic t_file;
        logic [2:0] c [6] = '{3'h5, 3'h6, 3'h7, 3'h6, 3'h5, 3'h4};
        logic [7:0] r [6] = '{8'hFF, 8'h00, 8'hFF, 8'h01, 8'h5A, 8'h37};
        logic [7:0] q [6] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'hA5, 8'h00};
        logic [5:0] dv = 6'h27;
        for (int i = 0; i < 6; i++) begin
            issue(c[i], dv[i], r[i]);
            chk_bit("we", dv[i], file_we_out);
            if (dv[i]) begin
                chk_byte("wdata", q[i], file_wdata_out);
                chk_byte("waddr", {5'h03, c[i]}, {3'h0, file_waddr_out});
            end else begin
                chk_byte("acc", q[i], accumulator_out);
            end
            chk_bit("zero", q[i] == 8'h00, zero_flag_out);
            chk_pc("pc", exp_pc, program_counter_out);
        end
    endtask : t_file
    task automatic t_wdt;
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_in);
            prescaler_to_wdt_in <= p[0];
            issue(3'h3, 1'b0, 8'h00);
            chk_bit("wdt_clr", 1'b1, watchdog_counter_clear_out);
            chk_bit("pre_clr", p[0], prescaler_clear_out);
            chk_bit("pd_n", 1'b1, powerdown_flag_n_out);
            @(posedge clk_in);
            #1;
            chk_bit("wdt_clr", 1'b0, watchdog_counter_clear_out);
        end
    endtask : t_wdt
    // An increment is offered in the flush cycle and must be dropped
    task automatic t_call(input logic [1:0] pg, input logic [7:0] lit);
        @(posedge clk_in);
        op_valid_in <= 1'b1;
        op_code_in <= 3'h2;
        literal_in <= lit;
        status_page_in <= pg;
        @(posedge clk_in);
        op_code_in <= 3'h7;
        dest_in <= 1'b1;
        #1;
        chk_pc("pc", {pg, 1'b0, lit}, program_counter_out);
        chk_pc("stack", exp_pc + 11'h001, stack_top_out);
        chk_bit("busy", 1'b1, busy_out);
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        #1;
        exp_pc = {pg, 1'b0, lit};
        chk_pc("pc", exp_pc, program_counter_out);
        chk_bit("we", 1'b0, file_we_out);
    endtask : t_call

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        #20000;
        fail_count++;
        print_verdict();
    end
    initial begin
        {reset_n_in, op_valid_in, dest_in, prescaler_to_wdt_in} = 4'h0;
        {op_code_in, file_addr_in, literal_in, file_rdata_in, status_page_in} = '0;
        {fail_count, checks_done, exp_pc} = '0;
        t_reset();
        t_acc();
        t_file();
        t_wdt();
        t_call(2'h3, 8'hC3);
        t_call(2'h1, 8'hFF);
        t_reset();
        t_call(2'h2, 8'h00);
        print_verdict();
    end
endmodule : test_clear_call_incdec_exec
